/* rtl/clock_mode_pkg.sv */
// shared constants and types for the clock mode controller
package clock_mode_pkg;

    // register byte offsets
    localparam logic [7:0] CLK_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SETTLE_SEL_OFFSET = 8'h04;
    localparam logic [7:0] PERIPH_SRC_OFFSET = 8'h08;
    localparam logic [7:0] MODE_STATUS_OFFSET = 8'h0c;

    // processor clock control fields
    localparam int DIV_SEL_LSB = 0;
    localparam int DIV_SEL_W = 3;
    localparam int SUB_SEL_BIT = 3;
    localparam int OSC_STOP_BIT = 4;
    localparam logic [2:0] DIV_SEL_RESET = 3'h0;

    // settle select: wait is 2**(SETTLE_BASE_EXP + sel) main clock periods
    localparam int SETTLE_SEL_W = 3;
    localparam int SETTLE_BASE_EXP = 13;
    localparam logic [2:0] SETTLE_SEL_MAX = 3'h4;
    localparam logic [2:0] SETTLE_SEL_RESET = 3'h2;
    localparam int SETTLE_RESET_EXP = 15;

    // peripheral clock source fields
    localparam int PSRC_W = 13;
    localparam int PSRC_CH1_WATCH = 0;
    localparam int PSRC_WATCH_SUB = 1;
    localparam int PSRC_NT_EXT_LSB = 2;
    localparam int PSRC_NT_CH1_LSB = 4;
    localparam int PSRC_IVB_SUB = 6;
    localparam int PSRC_WDOG2_SUB = 7;
    localparam int PSRC_ASYNC_EXT = 8;
    localparam int PSRC_CSER_EXT_LSB = 9;
    localparam int PSRC_RTO_NT = 12;
    localparam logic [12:0] PSRC_RESET = 13'h0000;

    // timing
    localparam longint HCLK_HZ = 40_000_000;
    localparam longint MAIN_OSC_FREQ_HZ = 4_000_000;
    localparam int MAIN_PERIOD_CYCLES = int'(HCLK_HZ / MAIN_OSC_FREQ_HZ);
    localparam int WAIT_W = 32;

    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SUB = 2'b01,
        MODE_STOP = 2'b10,
        MODE_SETTLE = 2'b11
    } clk_mode_e;

    // run enables for peripheral groups
    typedef struct packed {
        logic [4:0] wide_timer_run;
        logic [1:0] narrow_timer_run;
        logic interval_timer_b_run;
        logic watch_timer_run;
        logic second_watchdog_run;
        logic async_serial0_run;
        logic [2:0] clocked_serial_run;
        logic realtime_out_run;
        logic main_only_run;
    } periph_run_s;

endpackage : clock_mode_pkg

/* rtl/subclock_mode_clock_switch.sv */
// clock mode controller: stop release settle wait and subclock switching
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - interrupt wake waits programmed settle time
// - reset wake waits 2**15 main periods
// - subclock bit set in normal enters subclock
// - subclock mode selects subclock as system clock
// - oscillator stop bit halts main oscillator in subclock mode only
// - clear bit or reset leaves subclock mode
// - leaving subclock returns to normal main clock
// - wide timers 0, 2-4 halt without main
// - wide timer 1 runs on watch event
// - narrow timer runs from external input
// - narrow timer runs from enabled channel-1 compare
// - interval b, watch, watchdog 2 need subclock
// - async serial 0 needs external baud clock
// - clocked serials need external serial clock
// - realtime output needs externally counted narrow timer
module subclock_mode_clock_switch
    import clock_mode_pkg::*;
#(
    parameter int SETTLE_UNIT_CYCLES = MAIN_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // power events
    input wire logic stop_request,
    input wire logic wake_interrupt,
    input wire logic reset_pin_n,
    input wire logic first_watchdog_reset,
    input wire logic second_watchdog_reset,
    // clock control outputs
    output logic system_clock_is_sub,
    output logic main_osc_enable,
    output logic cpu_clock_run,
    output logic [2:0] clock_divider_select,
    output periph_run_s periph_run
);

    typedef struct packed {
        logic [1:0] pin_sync;
        logic dph_write;
        logic dph_valid;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
        logic [2:0] div_sel;
        logic sub_sel;
        logic osc_stop;
        logic [2:0] settle_sel;
        logic [PSRC_W-1:0] psrc;
        clk_mode_e mode;
        logic [WAIT_W-1:0] wait_cnt;
        periph_run_s run;
        logic sys_sub;
        logic osc_en;
        logic cpu_run;
    } state_s;

    state_s state_reg;
    state_s state_next;

    localparam state_s STATE_RESET = '{
        pin_sync: 2'b00,
        dph_write: 1'b0,
        dph_valid: 1'b0,
        dph_addr: 8'h00,
        rdata: 32'h0000_0000,
        div_sel: DIV_SEL_RESET,
        sub_sel: 1'b0,
        osc_stop: 1'b0,
        settle_sel: SETTLE_SEL_RESET,
        psrc: PSRC_RESET,
        mode: MODE_NORMAL,
        wait_cnt: 32'h0000_0000,
        run: '1,
        sys_sub: 1'b0,
        osc_en: 1'b1,
        cpu_run: 1'b1
    };

    // refuse unit counts whose longest wait overflows the counter
    if (SETTLE_UNIT_CYCLES < 1 || SETTLE_UNIT_CYCLES > 16384) begin : g_bad_unit
        $error("SETTLE_UNIT_CYCLES out of range");
    end

    // reset settle choice must itself be a legal choice
    if (SETTLE_SEL_RESET > SETTLE_SEL_MAX) begin : g_bad_settle_reset
        $error("SETTLE_SEL_RESET above SETTLE_SEL_MAX");
    end

    // longest programmed wait must fit the wait counter
    if (SETTLE_BASE_EXP + int'(SETTLE_SEL_MAX) + $clog2(SETTLE_UNIT_CYCLES + 1) > WAIT_W) begin : g_bad_wait_w
        $error("WAIT_W too narrow for the longest settle wait");
    end

    // settle wait in hclk cycles for a given power-of-two exponent
    function automatic logic [WAIT_W-1:0] settle_cycles(input int exp);
        longint cyc;
        cyc = (longint'(1) << exp) * longint'(SETTLE_UNIT_CYCLES);
        return cyc[WAIT_W-1:0];
    endfunction : settle_cycles

    // settle select above the longest wait reads back as the longest
    function automatic logic [2:0] clamp_settle(input logic [2:0] sel);
        logic [2:0] c;
        c = sel;
        if (c > SETTLE_SEL_MAX) begin
            c = SETTLE_SEL_MAX;
        end
        return c;
    endfunction : clamp_settle

    // cpu clock held while stopped or settling
    function automatic logic is_halted(input clk_mode_e m);
        return (m == MODE_STOP) || (m == MODE_SETTLE);
    endfunction : is_halted

    // transfer types that open an address phase
    function automatic logic is_transfer(input logic [1:0] t);
        return (t == HTRANS_NONSEQ) || (t == HTRANS_SEQ);
    endfunction : is_transfer

    // word aligned register offset from a bus address
    function automatic logic [7:0] word_addr(input logic [31:0] a);
        return {a[7:2], 2'b00};
    endfunction : word_addr

    // processor clock control word
    function automatic logic [31:0] ctrl_word(input state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[DIV_SEL_LSB +: DIV_SEL_W] = s.div_sel;
        w[SUB_SEL_BIT] = s.sub_sel;
        w[OSC_STOP_BIT] = s.osc_stop;
        return w;
    endfunction : ctrl_word

    // mode status word: mode, oscillator, clock source, cpu clock
    function automatic logic [31:0] status_word(input state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[1:0] = s.mode;
        w[2] = s.osc_en;
        w[3] = s.sys_sub;
        w[4] = s.cpu_run;
        return w;
    endfunction : status_word

    // apply one data-phase register write to a state copy
    function automatic state_s write_regs(input state_s s, input logic [7:0] a,
            input logic [31:0] d);
        state_s n;
        n = s;
        unique case (a)
            CLK_CTRL_OFFSET: begin
                n.div_sel = d[DIV_SEL_LSB +: DIV_SEL_W];
                n.sub_sel = d[SUB_SEL_BIT];
                n.osc_stop = d[OSC_STOP_BIT];
            end
            SETTLE_SEL_OFFSET: begin
                n.settle_sel = clamp_settle(d[SETTLE_SEL_W-1:0]);
            end
            PERIPH_SRC_OFFSET: begin
                n.psrc = d[PSRC_W-1:0];
            end
            default: begin
                n = s;
            end
        endcase
        return n;
    endfunction : write_regs

    // run enables for each peripheral group for a given main clock state
    function automatic periph_run_s periph_enables(input logic main_ok,
            input logic [PSRC_W-1:0] src);
        periph_run_s r;
        logic ch1_on;
        logic [1:0] nt_on;
        ch1_on = main_ok || (src[PSRC_CH1_WATCH] && src[PSRC_WATCH_SUB]);
        for (int i = 0; i < 2; i++) begin
            nt_on[i] = main_ok || src[PSRC_NT_EXT_LSB + i]
                || (src[PSRC_NT_CH1_LSB + i] && ch1_on);
        end
        r.wide_timer_run = {main_ok, main_ok, main_ok, ch1_on, main_ok};
        r.narrow_timer_run = nt_on;
        r.interval_timer_b_run = main_ok || src[PSRC_IVB_SUB];
        r.watch_timer_run = main_ok || src[PSRC_WATCH_SUB];
        r.second_watchdog_run = main_ok || src[PSRC_WDOG2_SUB];
        r.async_serial0_run = main_ok || src[PSRC_ASYNC_EXT];
        r.clocked_serial_run = main_ok ? 3'h7 : src[PSRC_CSER_EXT_LSB +: 3];
        r.realtime_out_run = main_ok || (src[PSRC_RTO_NT] && src[PSRC_NT_EXT_LSB]);
        r.main_only_run = main_ok;
        return r;
    endfunction : periph_enables

    // register read mux over a given state copy
    function automatic logic [31:0] read_word(input state_s s, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            CLK_CTRL_OFFSET: begin
                w = ctrl_word(s);
            end
            SETTLE_SEL_OFFSET: begin
                w[SETTLE_SEL_W-1:0] = s.settle_sel;
            end
            PERIPH_SRC_OFFSET: begin
                w[PSRC_W-1:0] = s.psrc;
            end
            MODE_STATUS_OFFSET: begin
                w = status_word(s);
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction : read_word

    logic any_reset;
    logic addr_phase;
    logic main_on;

    always_comb begin
        state_next = state_reg;
        state_next.pin_sync = {state_reg.pin_sync[0], ~reset_pin_n};
        any_reset = state_reg.pin_sync[1] | first_watchdog_reset | second_watchdog_reset;

        // register writes land in the data phase
        if (state_reg.dph_valid && state_reg.dph_write) begin
            state_next = write_regs(state_next, state_reg.dph_addr, hwdata);
        end

        // mode sequencing
        unique case (state_reg.mode)
            MODE_NORMAL: begin
                // stop wins over a same-cycle subclock entry
                if (stop_request) begin
                    state_next.mode = MODE_STOP;
                end else if (state_next.sub_sel) begin
                    state_next.mode = MODE_SUB;
                end
            end
            MODE_SUB: begin
                if (!state_next.sub_sel) begin
                    state_next.mode = MODE_NORMAL;
                end
            end
            MODE_STOP: begin
                if (wake_interrupt) begin
                    state_next.mode = MODE_SETTLE;
                    state_next.wait_cnt =
                        settle_cycles(SETTLE_BASE_EXP + int'(state_next.settle_sel));
                end
            end
            MODE_SETTLE: begin
                // last loaded count ends the wait on this edge
                if (state_reg.wait_cnt <= 32'h0000_0001) begin
                    state_next.mode = MODE_NORMAL;
                    state_next.wait_cnt = 32'h0000_0000;
                end else begin
                    state_next.wait_cnt = state_reg.wait_cnt - 32'h0000_0001;
                end
            end
        endcase

        // reset sources restore defaults and leave subclock mode
        if (any_reset) begin
            state_next.div_sel = DIV_SEL_RESET;
            state_next.sub_sel = 1'b0;
            state_next.osc_stop = 1'b0;
            state_next.settle_sel = SETTLE_SEL_RESET;
            state_next.psrc = PSRC_RESET;
            // a reset during stop or settle restarts the long wait
            if (is_halted(state_reg.mode)) begin
                state_next.mode = MODE_SETTLE;
                state_next.wait_cnt = settle_cycles(SETTLE_RESET_EXP);
            end else begin
                state_next.mode = MODE_NORMAL;
            end
        end

        // clock steering
        state_next.sys_sub = (state_next.mode == MODE_SUB);
        main_on = !(state_next.mode == MODE_STOP)
            && !(state_next.mode == MODE_SUB && state_next.osc_stop);
        // oscillator stays on through settle so the exit clock is stable
        state_next.osc_en = main_on;
        state_next.cpu_run = !is_halted(state_next.mode);

        // peripheral run enables, all held while the cpu clock is held
        state_next.run = periph_enables(main_on, state_next.psrc);
        if (is_halted(state_next.mode)) begin
            state_next.run = '0;
        end

        // address phase capture and read data from the updated copy
        addr_phase = hsel && hready && is_transfer(htrans);
        if (hready) begin
            state_next.dph_valid = addr_phase;
            state_next.dph_write = hwrite;
            state_next.dph_addr = word_addr(haddr);
            if (addr_phase && !hwrite) begin
                state_next.rdata = read_word(state_next, word_addr(haddr));
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;
    assign system_clock_is_sub = state_reg.sys_sub;
    assign main_osc_enable = state_reg.osc_en;
    assign cpu_clock_run = state_reg.cpu_run;
    assign clock_divider_select = state_reg.div_sel;
    assign periph_run = state_reg.run;

endmodule : subclock_mode_clock_switch

/* rtl/unused_placeholder_none.sv */
// intentionally empty design unit list
`timescale 1ns/1ps

/* bench/clock_mode_asserts.sv */
// concurrent checks on the clock mode controller ports
`timescale 1ns/1ps
module clock_mode_asserts
    import clock_mode_pkg::*;
#(
    parameter int SETTLE_UNIT_CYCLES = 1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus response
    input wire logic hreadyout,
    input wire logic hresp,
    // power events
    input wire logic reset_pin_n,
    input wire logic first_watchdog_reset,
    input wire logic second_watchdog_reset,
    // clock control
    input wire logic system_clock_is_sub,
    input wire logic main_osc_enable,
    input wire logic cpu_clock_run,
    input wire logic [2:0] clock_divider_select,
    input wire periph_run_s periph_run
);
    localparam int MIN_WAIT = (2 ** SETTLE_BASE_EXP) * SETTLE_UNIT_CYCLES;
    logic [31:0] low_cnt_reg;

    // cycles spent with the cpu clock held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_reg <= 32'h0000_0000;
        end else begin
            low_cnt_reg <= cpu_clock_run ? 32'h0000_0000 : low_cnt_reg + 32'h0000_0001;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_settle_min: assert property ($rose(cpu_clock_run) |-> low_cnt_reg >= MIN_WAIT)
        else $error("cpu clock resumed before settle time");
    chk_osc_only_sub: assert property (!main_osc_enable && cpu_clock_run |-> system_clock_is_sub)
        else $error("main oscillator off outside subclock mode");
    chk_wide_halt: assert property (!main_osc_enable |->
        periph_run.wide_timer_run[0] == 1'b0 && periph_run.wide_timer_run[4:2] == 3'h0)
        else $error("wide timer runs without main clock");
    chk_main_only: assert property (!main_osc_enable |-> !periph_run.main_only_run)
        else $error("main only group runs without main clock");
    chk_leave_main: assert property ($fell(system_clock_is_sub) |-> main_osc_enable)
        else $error("left subclock mode without main clock");
    chk_wdog_exit: assert property (first_watchdog_reset || second_watchdog_reset |=>
        !system_clock_is_sub && clock_divider_select == DIV_SEL_RESET)
        else $error("watchdog reset did not restore normal mode");
    chk_pin_exit: assert property (!reset_pin_n [*5] |-> !system_clock_is_sub)
        else $error("reset pin did not leave subclock mode");

    cover property ($rose(system_clock_is_sub));
    cover property ($fell(main_osc_enable) && system_clock_is_sub);
    cover property ($rose(cpu_clock_run));
endmodule : clock_mode_asserts

bind subclock_mode_clock_switch clock_mode_asserts #(.SETTLE_UNIT_CYCLES(SETTLE_UNIT_CYCLES))
    u_chk (.hclk, .hresetn, .hreadyout, .hresp, .reset_pin_n, .first_watchdog_reset,
    .second_watchdog_reset, .system_clock_is_sub, .main_osc_enable, .cpu_clock_run,
    .clock_divider_select, .periph_run);

/* bench/subclock_mode_clock_switch_tb_top.sv */
// testbench for the clock mode controller
`timescale 1ns/1ps
module subclock_mode_clock_switch_tb_top;
    import clock_mode_pkg::*;
    localparam int U = 1;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic stop_request = 0, wake_interrupt = 0, reset_pin_n = 1;
    logic first_watchdog_reset = 0, second_watchdog_reset = 0;
    logic hreadyout, hresp, hready, system_clock_is_sub, main_osc_enable, cpu_clock_run;
    logic [2:0] clock_divider_select;
    periph_run_s periph_run;
    int failures = 0, cmp_count = 0, cycles = 0, n;
    logic [12:0] srcs [5] = '{13'h1fff, 13'h0001, 13'h0033, 13'h1010, 13'h1004};
    logic [15:0] runs [5] = '{16'h17fe, 16'h0000, 16'h1680, 16'h0000, 16'h0202};

    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;

    subclock_mode_clock_switch #(.SETTLE_UNIT_CYCLES(U)) u_dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .stop_request,
        .wake_interrupt, .reset_pin_n, .first_watchdog_reset, .second_watchdog_reset,
        .system_clock_is_sub, .main_osc_enable, .cpu_clock_run, .clock_divider_select,
        .periph_run);

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // write, then let the outputs land
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        @(posedge hclk);
    endtask : wr

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        ahb(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rdchk

    task stop_wake(input logic by_wd, input int exp);
        stop_request <= 1'b1;
        @(posedge hclk);
        stop_request <= 1'b0;
        @(posedge hclk);
        check("cpu_run_stop", cpu_clock_run, 0);
        check("run_stop", periph_run, 0);
        if (by_wd) first_watchdog_reset <= 1'b1;
        else wake_interrupt <= 1'b1;
        @(posedge hclk);
        first_watchdog_reset <= 1'b0;
        wake_interrupt <= 1'b0;
        n = 0;
        while (cpu_clock_run !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        check("settle_len", n, exp + 1);
    endtask : stop_wake

    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            stop_test;
        end
    end

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("run_reset", periph_run, 16'hffff);
        rdchk(MODE_STATUS_OFFSET, 32'h0000_0014, "status_reset");
        rdchk(SETTLE_SEL_OFFSET, 32'h0000_0002, "settle_reset");
        rdchk(8'h10, 32'h0000_0000, "unmapped");
        wr(SETTLE_SEL_OFFSET, 32'h0000_0007);
        rdchk(SETTLE_SEL_OFFSET, 32'h0000_0004, "settle_clamp");
        $display("test registers done");
        wr(CLK_CTRL_OFFSET, 32'h0000_0005);
        wr(CLK_CTRL_OFFSET, 32'h0000_000d);
        check("sub_on", system_clock_is_sub, 1);
        check("div_kept", clock_divider_select, 3'h5);
        check("osc_kept", main_osc_enable, 1);
        wr(CLK_CTRL_OFFSET, 32'h0000_001d);
        check("osc_off", main_osc_enable, 0);
        check("cpu_sub", cpu_clock_run, 1);
        rdchk(MODE_STATUS_OFFSET, 32'h0000_0019, "status_sub");
        for (int i = 0; i < 5; i++) begin
            wr(PERIPH_SRC_OFFSET, {19'h0, srcs[i]});
            check("run_sub", periph_run, {16'h0, runs[i]});
        end
        check("run_sub_last", periph_run, 16'h0202);
        $display("test subclock entry done");
        wr(CLK_CTRL_OFFSET, 32'h0000_000d);
        check("osc_back", main_osc_enable, 1);
        wr(CLK_CTRL_OFFSET, 32'h0000_0005);
        check("sub_off", system_clock_is_sub, 0);
        check("run_main", periph_run, 16'hffff);
        rdchk(MODE_STATUS_OFFSET, 32'h0000_0014, "status_normal");
        $display("test subclock exit done");
        wr(SETTLE_SEL_OFFSET, 32'h0000_0000);
        stop_wake(1'b0, (2 ** SETTLE_BASE_EXP) * U);
        stop_wake(1'b1, (2 ** SETTLE_RESET_EXP) * U);
        check("div_wd", clock_divider_select, 3'h0);
        $display("test stop release done");
        wr(CLK_CTRL_OFFSET, 32'h0000_000d);
        second_watchdog_reset <= 1'b1;
        @(posedge hclk);
        second_watchdog_reset <= 1'b0;
        @(posedge hclk);
        check("wd_exit", system_clock_is_sub, 0);
        wr(CLK_CTRL_OFFSET, 32'h0000_000d);
        wr(CLK_CTRL_OFFSET, 32'h0000_001d);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge hclk);
        check("pin_exit", system_clock_is_sub, 0);
        check("pin_osc", main_osc_enable, 1);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge hclk);
        $display("test reset exit done");
        stop_test;
    end
endmodule : subclock_mode_clock_switch_tb_top
